//--- verilog/asct_pkg.sv
// Package with pin bundles, states and timing counts for the static memory host controller.
package asct_pkg;

  // Clock rate in MHz and period in ns.
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

  // Widths of the memory pins.
  localparam int ADDR_W = 20;
  localparam int DATA_W = 4;

  // Slowest-grade timing figures in ns, so that every grade is served.
  localparam int CYCLE_TIME_MIN_NS = 15;
  localparam int ADDRESS_ACCESS_MAX_NS = 15;
  localparam int CHIP_ENABLE_ACCESS_MAX_NS = 15;
  localparam int OUTPUT_ENABLE_ACCESS_MAX_NS = 7;
  localparam int OUTPUT_ENABLE_TURN_OFF_MAX_NS = 7;
  localparam int CHIP_ENABLE_TURN_OFF_MAX_NS = 7;
  localparam int WRITE_ADDRESS_SETUP_MIN_NS = 0;
  localparam int ADDRESS_TO_WRITE_END_MIN_NS = 12;
  localparam int WRITE_PULSE_MIN_NS = 12;
  localparam int DATA_TO_WRITE_END_MIN_NS = 7;
  localparam int WRITE_TURN_OFF_MAX_NS = 7;
  localparam int WRITE_RECOVERY_MIN_NS = 0;

  // Ceiling division of ns by the clock period, never below one cycle.
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  // Cycle counts derived from the figures above.
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] READ_WAIT_CYC =
    CNT_W'(ns_to_cycles(CHIP_ENABLE_ACCESS_MAX_NS) + 1);
  localparam logic [CNT_W-1:0] TURN_OFF_CYC =
    CNT_W'(ns_to_cycles(OUTPUT_ENABLE_TURN_OFF_MAX_NS));
  localparam logic [CNT_W-1:0] WRITE_PULSE_CYC =
    CNT_W'(ns_to_cycles(WRITE_PULSE_MIN_NS));
  localparam logic [CNT_W-1:0] CYCLE_MIN_CYC =
    CNT_W'(ns_to_cycles(CYCLE_TIME_MIN_NS));
  // Extra read-wait cycles that cover the two-stage synchroniser on the data pins.
  localparam logic [CNT_W-1:0] SYNC_MARGIN_CYC = 4'h2;

  // Request from the user side.
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] wdata;
  } asct_req_s;

  // Controller states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_RDOFF = 3'b010,
    ST_WSET  = 3'b011,
    ST_WPUL  = 3'b100,
    ST_WEND  = 3'b101
  } asct_state_e;

endpackage : asct_pkg

//--- verilog/asct_sync.sv
// Two flip-flop synchroniser for the data pins read back from the memory.
`timescale 1ns/10ps
`default_nettype none
module asct_sync (
  // Clock and reset.
  input  wire logic                        i_mclk,
  input  wire logic                        i_reset,
  // Asynchronous input and synchronised output.
  input  wire logic [asct_pkg::DATA_W-1:0] i_async,
  output logic      [asct_pkg::DATA_W-1:0] o_sync
);

  logic [asct_pkg::DATA_W-1:0] meta_r;
  logic [asct_pkg::DATA_W-1:0] sync_r;

  // First stage feeds only the second stage.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule : asct_sync
`default_nettype wire

//--- verilog/asct_host.sv
// Host controller that runs read and write cycles on an asynchronous 1M x 4 static memory.
// Function
// RULE1: Write happens only while chip enable and write enable are both low.
// RULE2: Write enable stays high through every read cycle.
// RULE3: Output enable stays high during writes so memory keeps pins released.
// RULE4: Each read address is held at least the read cycle time.
// RULE5: Read data is valid within address access time after address settles.
// RULE6: Data is valid within enable access time of chip enable falling.
// RULE7: Data is valid within output enable access time of output enable falling.
// RULE8: Memory holds old data at least 2 ns after an address change.
// RULE9: Memory drives no earlier than 3 ns after chip enable falls.
// RULE10: Memory releases pins within turn-off time after chip enable rises.
// RULE11: Memory releases pins within turn-off time after output enable rises.
// RULE12: Memory turn-off is always shorter than its turn-on.
// RULE13: Each write address is held at least the write cycle time.
// RULE14: Address is stable before write enable falls.
// RULE15: Address is valid long enough before the write ends.
// RULE16: Write enable is held low at least the write pulse width.
// RULE17: Write data is valid long enough before the write ends.
// RULE18: Memory releases pins within turn-off time after write enable falls.
// RULE19: Memory drives again no earlier than 3 ns after write enable rises.
// RULE20: With enables low, memory output follows each address change.
// RULE21: Address and write data stay stable until the write-ending edge.
// RULE22: Address is 20 bits, words are 4 bits, chip enable high idles.
`timescale 1ns/10ps
`default_nettype none
module asct_host (
  // Clock and reset.
  input  wire logic                          i_mclk,
  input  wire logic                          i_reset,
  // User request port.
  input  wire logic                          i_req_valid,
  input  wire asct_pkg::asct_req_s           i_req,
  output logic                               o_req_ready,
  // User read answer.
  output logic                               o_rd_valid,
  output logic      [asct_pkg::DATA_W-1:0]   o_rd_data,
  // Memory address and control pins, strobes active low.
  output logic      [asct_pkg::ADDR_W-1:0]   o_word_address,
  output logic                               o_chip_enable_n,
  output logic                               o_output_enable_n,
  output logic                               o_write_enable_n,
  // Memory data pins as input, output and output enable.
  input  wire logic [asct_pkg::DATA_W-1:0]   i_dq,
  output logic      [asct_pkg::DATA_W-1:0]   o_dq,
  output logic                               o_dq_oe
);

  asct_pkg::asct_state_e           state_r;
  asct_pkg::asct_state_e           state_nxt;
  logic [asct_pkg::CNT_W-1:0]      cnt_r;
  logic [asct_pkg::CNT_W-1:0]      cyc_r;
  logic [asct_pkg::DATA_W-1:0]     dq_sync;
  logic                            cnt_done;
  logic                            take;
  logic                            rd_done;

  // A request is taken only in the idle state when valid meets ready.
  function automatic logic req_taken(input asct_pkg::asct_state_e st,
                                     input logic                  valid,
                                     input logic                  ready);
    return (st == asct_pkg::ST_IDLE) && valid && ready;
  endfunction : req_taken

  // Chip enable is low in the read, write setup and write pulse states.
  function automatic logic in_access(input asct_pkg::asct_state_e st);
    return (st == asct_pkg::ST_READ) || (st == asct_pkg::ST_WSET) ||
           (st == asct_pkg::ST_WPUL);
  endfunction : in_access

  // Only the second synchroniser stage feeds the read sample.
  // Synchronised copy of the data pins.
  asct_sync u_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async (i_dq),
    .o_sync  (dq_sync)
  );

  // Phase count has run out; take and the end of the read wait serve several processes.
  assign cnt_done = (cnt_r == '0);
  assign take     = req_taken(state_r, i_req_valid, o_req_ready);
  assign rd_done  = (state_r == asct_pkg::ST_READ) && cnt_done;

  // Next-state decode of the cycle sequencer.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      asct_pkg::ST_IDLE: begin
        if (take) begin
          state_nxt = i_req.write ? asct_pkg::ST_WSET : asct_pkg::ST_READ;
        end
      end
      asct_pkg::ST_READ: begin
        if (cnt_done) begin
          state_nxt = asct_pkg::ST_RDOFF;
        end
      end
      asct_pkg::ST_RDOFF: begin
        if (cnt_done) begin
          state_nxt = asct_pkg::ST_IDLE;
        end
      end
      asct_pkg::ST_WSET: begin
        // One setup cycle with chip enable low before the write strobe falls.
        state_nxt = asct_pkg::ST_WPUL;
      end
      asct_pkg::ST_WPUL: begin
        if (cnt_done) begin
          state_nxt = asct_pkg::ST_WEND;
        end
      end
      asct_pkg::ST_WEND: begin
        // Write enable and chip enable rose together; host data still stands here.
        state_nxt = asct_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = asct_pkg::ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= asct_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase counter loaded on entry to the read, read turn-off and write pulse states.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cnt_r <= '0;
    end else if (take && !i_req.write) begin
      // Extra cycles cover the synchroniser before the read word is sampled.
      cnt_r <= asct_pkg::READ_WAIT_CYC + asct_pkg::SYNC_MARGIN_CYC; // see RULE5 RULE6 RULE7
    end else if (rd_done) begin
      cnt_r <= asct_pkg::TURN_OFF_CYC; // see RULE10 see RULE11 see RULE12
    end else if (state_r == asct_pkg::ST_WSET) begin
      cnt_r <= asct_pkg::WRITE_PULSE_CYC - 4'h1; // see RULE16
    end else if (!cnt_done) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Cycle-time counter keeps every address on the pins long enough.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cyc_r <= '0;
    end else if (take) begin
      // It starts at the take, so each address stands at least the cycle time.
      cyc_r <= asct_pkg::CYCLE_MIN_CYC; // see RULE4 see RULE13
    end else if (cyc_r != '0) begin
      cyc_r <= cyc_r - 4'h1;
    end
  end

  // Ready once idle and the previous address has met the cycle time.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_req_ready <= 1'b0;
    end else begin
      // Dropping ready on the take edge keeps a held request from being taken twice;
      // the cycle-time count lets ready rise on the same edge where it runs out.
      o_req_ready <= (state_nxt == asct_pkg::ST_IDLE) && (cyc_r <= 4'h1) && !take;
    end
  end

  // Address and write data latch at request; held to the end of the cycle.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_word_address <= '0;
      o_dq           <= '0;
    end else if (take) begin
      // Both stand from the take to the next take, well past the write end.
      o_word_address <= i_req.word_address; // see RULE14 see RULE15 see RULE21 see RULE22
      o_dq           <= i_req.wdata; // see RULE17 see RULE21
    end
  end

  // Control strobes; the write window is enables overlapping low.
  // Output enable never falls in a write, so the memory keeps its pins released.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_chip_enable_n   <= 1'b1;
      o_output_enable_n <= 1'b1;
      o_write_enable_n  <= 1'b1;
    end else begin
      o_chip_enable_n   <= !in_access(state_nxt); // see RULE22
      o_output_enable_n <= !(state_nxt == asct_pkg::ST_READ); // see RULE3 see RULE2
      o_write_enable_n  <= !(state_nxt == asct_pkg::ST_WPUL); // see RULE1 see RULE2
    end
  end

  // Host drives the data pins from the start of the write pulse, after the memory let go.
  // It lets go one cycle after write enable rises, so data holds past the write end.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_dq_oe <= 1'b0;
    end else begin
      o_dq_oe <= (state_nxt == asct_pkg::ST_WPUL) ||
                 (state_nxt == asct_pkg::ST_WEND); // see RULE18 see RULE19 see RULE17
    end
  end

  // Read data sampled from the synchroniser at the end of the access wait.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      // The pulse lasts one cycle because the wait ends for one cycle only.
      o_rd_valid <= rd_done; // see RULE8 see RULE20
      if (rd_done) begin
        o_rd_data <= dq_sync; // see RULE9
      end
    end
  end

endmodule : asct_host
`default_nettype wire

//--- verification/asct_host_props.sv
// Checker of the host controller's pin timing.
`timescale 1ns/10ps
`default_nettype none
module asct_host_props (
  // Clock and reset.
  input wire logic                        i_mclk,
  input wire logic                        i_reset,
  // Request side.
  input wire logic                        i_req_valid,
  input wire asct_pkg::asct_req_s         i_req,
  input wire logic                        o_req_ready,
  input wire logic                        o_rd_valid,
  // Memory pins.
  input wire logic [asct_pkg::ADDR_W-1:0] o_word_address,
  input wire logic                        o_chip_enable_n,
  input wire logic                        o_output_enable_n,
  input wire logic                        o_write_enable_n,
  input wire logic [asct_pkg::DATA_W-1:0] o_dq,
  input wire logic                        o_dq_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // A request is taken when valid meets ready.
  wire take = i_req_valid && o_req_ready;
  a_write_in_overlap: assert property (!o_write_enable_n |-> !o_chip_enable_n)
    else $error("write strobe low without chip enable");
  a_read_we_high: assert property (!o_output_enable_n |-> o_write_enable_n)
    else $error("write strobe low in a read");
  a_write_oe_high: assert property ((!o_write_enable_n || o_dq_oe) |-> o_output_enable_n)
    else $error("output enable low while writing");
  a_read_answer_time: assert property ((take && !i_req.write) |=>
    (!o_chip_enable_n && !o_output_enable_n) ##6 o_rd_valid)
    else $error("read answer late or early");
  a_cycle_min_gap: assert property (take |=> !o_req_ready [*4])
    else $error("next request accepted too soon");
  a_addr_hold_sel: assert property ((!o_chip_enable_n && $past(!o_chip_enable_n))
    |-> $stable(o_word_address))
    else $error("address moved while selected");
  a_write_setup_ok: assert property ($fell(o_write_enable_n) |-> !o_chip_enable_n
    && o_dq_oe && $stable(o_word_address) && $stable(o_dq))
    else $error("write started before address and data set");
  a_write_pulse_len: assert property ($fell(o_write_enable_n) |=> !o_write_enable_n
    ##1 (o_write_enable_n && $stable(o_word_address) && $stable(o_dq)))
    else $error("write pulse width or hold wrong");
  a_drive_after_off: assert property ($rose(o_dq_oe) |-> $past(o_output_enable_n, 2))
    else $error("host drives before memory released pins");
  c_read: cover property (take && !i_req.write);
  c_write: cover property (take && i_req.write);
  c_answer: cover property (o_rd_valid);
endmodule : asct_host_props
bind asct_host asct_host_props chk_u (.i_mclk, .i_reset, .i_req_valid, .i_req, .o_req_ready,
  .o_rd_valid, .o_word_address, .o_chip_enable_n, .o_output_enable_n, .o_write_enable_n,
  .o_dq, .o_dq_oe);
`default_nettype wire

//--- verification/asct_mem_model.sv
// Behavioural static memory that answers the host controller.
`timescale 1ns/10ps
`default_nettype none
module asct_mem_model (
  // Control pins.
  input  wire logic [19:0] i_word_address,
  input  wire logic        i_chip_enable_n,
  input  wire logic        i_output_enable_n,
  input  wire logic        i_write_enable_n,
  // Host data and level on the wire.
  input  wire logic [3:0]  i_host_dq,
  input  wire logic        i_host_oe,
  output logic      [3:0]  o_wire_dq
);
  logic [3:0] mem_r [0:20'hFFFFF];
  logic [3:0] out_r = 4'h0;
  logic [3:0] last_r = 4'h0;
  logic       drv_r = 1'b0;
  wire        rd_en = !i_chip_enable_n && !i_output_enable_n && i_write_enable_n;
  // Data lags address and enables by the slowest access time, old word held meanwhile.
  always @(i_word_address or rd_en) out_r <= #15 mem_r[i_word_address];
  // Drivers turn on after 3 ns and off after 2 ns, so off is always quicker.
  always @(rd_en) drv_r <= #(rd_en ? 3 : 2) rd_en;
  // The word is stored at the end of the overlap of both strobes.
  always @(posedge (i_chip_enable_n | i_write_enable_n)) mem_r[i_word_address] <= o_wire_dq;
  // A released wire shows the inverse of its last driven value.
  always @* if (i_host_oe || drv_r) last_r = i_host_oe ? i_host_dq : out_r;
  assign o_wire_dq = i_host_oe ? i_host_dq : (drv_r ? out_r : ~last_r);
endmodule : asct_mem_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench of the static memory host controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench;
  logic                        i_mclk = 1'b0;
  logic                        i_reset = 1'b1;
  logic                        i_req_valid = 1'b0;
  asct_pkg::asct_req_s         i_req = '0;
  logic                        o_req_ready, o_rd_valid, o_chip_enable_n, o_output_enable_n;
  logic                        o_write_enable_n, o_dq_oe;
  logic [asct_pkg::DATA_W-1:0] o_rd_data, o_dq, wire_dq;
  logic [asct_pkg::ADDR_W-1:0] o_word_address;
  logic [asct_pkg::DATA_W-1:0] shadow [logic [asct_pkg::ADDR_W-1:0]];
  logic [asct_pkg::ADDR_W-1:0] used_q [$];
  int                          fail_count = 0;
  int                          cmp_count = 0;
  // Clock of 10 ns.
  initial forever #5 i_mclk = ~i_mclk;
  asct_host dut_u (.i_mclk, .i_reset, .i_req_valid, .i_req, .o_req_ready, .o_rd_valid,
    .o_rd_data, .o_word_address, .o_chip_enable_n, .o_output_enable_n, .o_write_enable_n,
    .i_dq(wire_dq), .o_dq, .o_dq_oe);
  asct_mem_model mem_u (.i_word_address(o_word_address), .i_chip_enable_n(o_chip_enable_n),
    .i_output_enable_n(o_output_enable_n), .i_write_enable_n(o_write_enable_n),
    .i_host_dq(o_dq), .i_host_oe(o_dq_oe), .o_wire_dq(wire_dq));
  // Expected word: the last one written to the address.
  function automatic logic [3:0] exp_word(input logic [19:0] a);
    return shadow.exists(a) ? shadow[a] : 4'h0;
  endfunction : exp_word
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // A used-up wait counts as a mismatch and ends the run.
  task automatic bound(input int n);
    if (n >= 50) begin
      fail_count++;
      end_of_test();
    end
  endtask : bound
  // One request held until taken; a read then checks the returned word.
  task automatic access(input logic wr, input logic [19:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_req_valid <= 1'b1;
    i_req <= '{write: wr, word_address: a, wdata: d};
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_req_ready !== 1'b1 && n < 50);
    bound(n);
    i_req_valid <= 1'b0;
    if (wr) begin
      shadow[a] = d;
      used_q.push_back(a);
    end else begin
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (o_rd_valid !== 1'b1 && n < 50);
      bound(n);
      `CHK(o_rd_data, exp_word(a))
    end
  endtask : access
  // Main sequence: corner addresses, overwrite, then a random mix.
  initial begin
    logic [19:0] a;
    void'($urandom(32'hB69D05AC));
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'b0;
    access(1'b1, 20'h00000, 4'hA);
    access(1'b1, 20'hFFFFF, 4'h5);
    access(1'b1, 20'h80000, 4'hC);
    access(1'b0, 20'h00000, 4'h0);
    access(1'b1, 20'h00000, 4'h3);
    access(1'b0, 20'hFFFFF, 4'h0);
    access(1'b0, 20'h80000, 4'h0);
    access(1'b0, 20'h00000, 4'h0);
    $display("test corners done");
    for (int i = 0; i < 60; i++) begin
      a = used_q[$urandom % used_q.size()];
      if ($urandom % 2) access(1'b1, 20'($urandom), 4'($urandom));
      else access(1'b0, a, 4'h0);
    end
    $display("test random done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
